//--- hw/cfg_ctl_pkg.sv
// Purpose: constants for the configuration control register bank
// Assumes: 32-bit apb data, word aligned registers
// Notes:   offsets and key values are locally chosen
// =============================================================
// package
package cfg_ctl_pkg;
   // register byte offsets
   localparam logic [11:0] CONFIG_CONTROL_OFS = 12'h000;
   localparam logic [11:0] UNLOCK_KEY_OFS     = 12'h004;
   localparam logic [11:0] PIN_SELECT_OFS     = 12'h008;
   localparam logic [11:0] MODULE_DISABLE_OFS = 12'h00C;
   // field positions
   localparam int PIN_LOCK_BIT   = 13;
   localparam int MOD_LOCK_BIT   = 12;
   localparam int DEBUG_EN_BIT   = 3;
   localparam int TDO_USE_BIT    = 0;
   // reset values
   localparam logic PIN_LOCK_RST = 1'b0;
   localparam logic MOD_LOCK_RST = 1'b0;
   localparam logic DEBUG_EN_RST = 1'b1;
   localparam logic TDO_USE_RST  = 1'b1;
   localparam logic [31:0] PIN_SELECT_RST     = 32'h0000_0000;
   localparam logic [31:0] MODULE_DISABLE_RST = 32'h0000_0000;
   // bits 2 and 1 read as one, others unimplemented read zero
   localparam logic [31:0] READ_ONE_MASK = 32'h0000_0006;
   // unlock keys, written in this order to the key register
   localparam logic [31:0] UNLOCK_KEY1 = 32'hAA99_6655;
   localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99AA;
   // unlock sequencer states
   typedef enum logic [2:0] {
      KEY_IDLE  = 3'b001,
      KEY_HALF  = 3'b010,
      KEY_OPEN  = 3'b100
   } key_state_t;
endpackage : cfg_ctl_pkg

//--- hw/unlock_seq.sv
// Purpose: two-word unlock sequencer for the lock bits
// Assumes: key writes arrive as one-cycle strobes
// Notes:   unlock stays open until a lock bit change or the next key write
// =============================================================
`timescale 1ns/1ps
module unlock_seq (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // key write strobe and data
   input  wire logic        key_we,
   input  wire logic [31:0] key_data,
   // consume strobe from a lock bit write
   input  wire logic        consume,
   // status
   output logic             unlocked
);
   cfg_ctl_pkg::key_state_t state;

   // any wrong key restarts the sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= cfg_ctl_pkg::KEY_IDLE;
      end else if (key_we) begin
         if (key_data == cfg_ctl_pkg::UNLOCK_KEY1) begin
            state <= cfg_ctl_pkg::KEY_HALF;
         end else if (key_data == cfg_ctl_pkg::UNLOCK_KEY2 &&
                      state == cfg_ctl_pkg::KEY_HALF) begin
            state <= cfg_ctl_pkg::KEY_OPEN;
         end else begin
            state <= cfg_ctl_pkg::KEY_IDLE;
         end
      end else if (consume) begin
         state <= cfg_ctl_pkg::KEY_IDLE;
      end
   end

   assign unlocked = (state == cfg_ctl_pkg::KEY_OPEN);
endmodule : unlock_seq

//--- hw/config_control_lock_register.sv
// Purpose: configuration control register with lock bits over apb
// Assumes: apb3 slave, zero wait states, 32-bit data
// Notes:   lock changes need the unlock sequence on the key register
// What this block does
// - pin select lock set blocks writes to pin select registers
// - module disable lock set blocks writes to module disable registers
// - debug port enable output follows bit 3
// - bit 0 selects two-wire debug use of data output pin
// - bits 31 to 14 read zero, writes ignored
// - bits 11 to 4 read zero, writes discarded
// - bits 2 and 1 always read one
// =============================================================
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module config_control_lock_register (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // controlled state
   output logic             debug_port_enable,
   output logic             two_wire_output_pin_use,
   output logic             pin_select_lock,
   output logic             module_disable_lock,
   output logic [31:0]      pin_select_registers,
   output logic [31:0]      module_disable_registers
);
   // =============================================================
   // elaboration check
   // both lock fields must sit inside the word at distinct places
   if (cfg_ctl_pkg::PIN_LOCK_BIT > 31 || cfg_ctl_pkg::MOD_LOCK_BIT > 31 ||
       cfg_ctl_pkg::PIN_LOCK_BIT == cfg_ctl_pkg::MOD_LOCK_BIT) begin : g_bad_fields
      $error("lock field positions do not fit the register word");
   end

   // =============================================================
   // reset synchroniser
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // =============================================================
   // apb decode
   logic wr_en;
   logic access;
   logic sel_cfg;
   logic sel_key;
   logic sel_pin;
   logic sel_mod;
   logic mapped;
   assign access  = psel && penable;
   assign wr_en   = access && pwrite;
   assign sel_cfg = (paddr == cfg_ctl_pkg::CONFIG_CONTROL_OFS);
   assign sel_key = (paddr == cfg_ctl_pkg::UNLOCK_KEY_OFS);
   assign sel_pin = (paddr == cfg_ctl_pkg::PIN_SELECT_OFS);
   assign sel_mod = (paddr == cfg_ctl_pkg::MODULE_DISABLE_OFS);
   assign mapped  = sel_cfg || sel_key || sel_pin || sel_mod;
   assign pready  = 1'b1;                 // no wait states needed
   assign pslverr = access && !mapped;    // unmapped answers an error

   // =============================================================
   // unlock sequencer
   logic unlocked;
   logic lock_change;
   assign lock_change = wr_en && sel_cfg &&
      ((pwdata[cfg_ctl_pkg::PIN_LOCK_BIT] != pin_select_lock) ||
       (pwdata[cfg_ctl_pkg::MOD_LOCK_BIT] != module_disable_lock));

   unlock_seq unlock_seq_i (
      .clk      (clk),
      .rst_n    (rst_n),
      .key_we   (wr_en && sel_key),
      .key_data (pwdata),
      .consume  (lock_change),
      .unlocked (unlocked)
   );

   // =============================================================
   // lock bits, only change once unlocked
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_select_lock     <= cfg_ctl_pkg::PIN_LOCK_RST;
         module_disable_lock <= cfg_ctl_pkg::MOD_LOCK_RST;
      end else if (wr_en && sel_cfg && unlocked) begin
         pin_select_lock     <= pwdata[cfg_ctl_pkg::PIN_LOCK_BIT];
         module_disable_lock <= pwdata[cfg_ctl_pkg::MOD_LOCK_BIT];
      end
   end

   // plain control bits update on every config write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_port_enable       <= cfg_ctl_pkg::DEBUG_EN_RST;
         two_wire_output_pin_use <= cfg_ctl_pkg::TDO_USE_RST;
      end else if (wr_en && sel_cfg) begin
         debug_port_enable       <= pwdata[cfg_ctl_pkg::DEBUG_EN_BIT];
         two_wire_output_pin_use <= pwdata[cfg_ctl_pkg::TDO_USE_BIT];
      end
   end

   // =============================================================
   // guarded peripheral registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_select_registers <= cfg_ctl_pkg::PIN_SELECT_RST;
      end else if (wr_en && sel_pin && !pin_select_lock) begin
         pin_select_registers <= pwdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         module_disable_registers <= cfg_ctl_pkg::MODULE_DISABLE_RST;
      end else if (wr_en && sel_mod && !module_disable_lock) begin
         module_disable_registers <= pwdata;
      end
   end

   // =============================================================
   // read data, registered in the setup phase
   // read setup cycle, shared by the read mux and its checks
   logic        rd_setup;
   assign rd_setup = psel && !penable && !pwrite;
   logic [31:0] cfg_word;
   always_comb begin
      cfg_word = cfg_ctl_pkg::READ_ONE_MASK;
      cfg_word[cfg_ctl_pkg::PIN_LOCK_BIT] = pin_select_lock;
      cfg_word[cfg_ctl_pkg::MOD_LOCK_BIT] = module_disable_lock;
      cfg_word[cfg_ctl_pkg::DEBUG_EN_BIT] = debug_port_enable;
      cfg_word[cfg_ctl_pkg::TDO_USE_BIT]  = two_wire_output_pin_use;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         if (sel_cfg) begin
            prdata <= cfg_word;
         end else if (sel_key) begin
            prdata <= {31'h0000_0000, unlocked};
         end else if (sel_pin) begin
            prdata <= pin_select_registers;
         end else if (sel_mod) begin
            prdata <= module_disable_registers;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // =============================================================
   // checks
   property p_pin_locked;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_pin && pin_select_lock) |=> $stable(pin_select_registers);
   endproperty
   a_pin_locked: assert property (p_pin_locked) else $error("pin select written while locked");

   property p_mod_locked;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_mod && module_disable_lock) |=> $stable(module_disable_registers);
   endproperty
   a_mod_locked: assert property (p_mod_locked) else $error("module disable written while locked");

   property p_mod_open;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_mod && !module_disable_lock) |=> (module_disable_registers == $past(pwdata));
   endproperty
   a_mod_open: assert property (p_mod_open) else $error("module disable write lost");

   property p_debug_en;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_cfg) |=> (debug_port_enable == $past(pwdata[cfg_ctl_pkg::DEBUG_EN_BIT]));
   endproperty
   a_debug_en: assert property (p_debug_en) else $error("debug enable not updated");

   property p_tdo_use;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_cfg) |=>
         (two_wire_output_pin_use == $past(pwdata[cfg_ctl_pkg::TDO_USE_BIT]));
   endproperty
   a_tdo_use: assert property (p_tdo_use) else $error("two-wire pin use not updated");

   property p_hi_zero;
      @(posedge clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && sel_cfg) |=> (prdata[31:14] == 18'h00000);
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper bits read nonzero");

   property p_mid_zero;
      @(posedge clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && sel_cfg) |=> (prdata[11:4] == 8'h00);
   endproperty
   a_mid_zero: assert property (p_mid_zero) else $error("middle bits read nonzero");

   property p_ones;
      @(posedge clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && sel_cfg) |=> (prdata[2:1] == 2'h3);
   endproperty
   a_ones: assert property (p_ones) else $error("bits 2:1 not read as one");

   property p_lock_keep;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_cfg && !unlocked) |=> $stable(pin_select_lock) && $stable(module_disable_lock);
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("lock changed without unlock");

   // =============================================================
   // further checks on holding, opening and read-back
   property p_pin_open;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_pin && !pin_select_lock) |=> (pin_select_registers == $past(pwdata));
   endproperty
   a_pin_open: assert property (p_pin_open) else $error("pin select write lost");

   property p_pin_idle;
      @(posedge clk) disable iff (!rst_n)
      !(wr_en && sel_pin) |=> $stable(pin_select_registers);
   endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("pin select moved without write");

   property p_mod_idle;
      @(posedge clk) disable iff (!rst_n)
      !(wr_en && sel_mod) |=> $stable(module_disable_registers);
   endproperty
   a_mod_idle: assert property (p_mod_idle) else $error("module disable moved without write");

   property p_pin_lock_open;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_cfg && unlocked) |=>
         (pin_select_lock == $past(pwdata[cfg_ctl_pkg::PIN_LOCK_BIT]));
   endproperty
   a_pin_lock_open: assert property (p_pin_lock_open) else $error("pin lock write lost");

   property p_mod_lock_open;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && sel_cfg && unlocked) |=>
         (module_disable_lock == $past(pwdata[cfg_ctl_pkg::MOD_LOCK_BIT]));
   endproperty
   a_mod_lock_open: assert property (p_mod_lock_open) else $error("module lock write lost");

   property p_lock_idle;
      @(posedge clk) disable iff (!rst_n)
      !(wr_en && sel_cfg) |=> $stable(pin_select_lock) && $stable(module_disable_lock);
   endproperty
   a_lock_idle: assert property (p_lock_idle) else $error("lock moved without write");

   property p_debug_idle;
      @(posedge clk) disable iff (!rst_n)
      !(wr_en && sel_cfg) |=> $stable(debug_port_enable);
   endproperty
   a_debug_idle: assert property (p_debug_idle) else $error("debug enable moved alone");

   property p_tdo_idle;
      @(posedge clk) disable iff (!rst_n)
      !(wr_en && sel_cfg) |=> $stable(two_wire_output_pin_use);
   endproperty
   a_tdo_idle: assert property (p_tdo_idle) else $error("two-wire pin use moved alone");

   // one lock change per unlock, so a stray second write cannot relock
   property p_unlock_spent;
      @(posedge clk) disable iff (!rst_n)
      lock_change |=> !unlocked;
   endproperty
   a_unlock_spent: assert property (p_unlock_spent) else $error("unlock not spent");

   property p_rd_pin_lock;
      @(posedge clk) disable iff (!rst_n)
      (rd_setup && sel_cfg) |=>
         (prdata[cfg_ctl_pkg::PIN_LOCK_BIT] == $past(pin_select_lock));
   endproperty
   a_rd_pin_lock: assert property (p_rd_pin_lock) else $error("pin lock read wrong");

   property p_rd_mod_lock;
      @(posedge clk) disable iff (!rst_n)
      (rd_setup && sel_cfg) |=>
         (prdata[cfg_ctl_pkg::MOD_LOCK_BIT] == $past(module_disable_lock));
   endproperty
   a_rd_mod_lock: assert property (p_rd_mod_lock) else $error("module lock read wrong");

   property p_rd_debug;
      @(posedge clk) disable iff (!rst_n)
      (rd_setup && sel_cfg) |=>
         (prdata[cfg_ctl_pkg::DEBUG_EN_BIT] == $past(debug_port_enable));
   endproperty
   a_rd_debug: assert property (p_rd_debug) else $error("debug enable read wrong");

   property p_rd_tdo;
      @(posedge clk) disable iff (!rst_n)
      (rd_setup && sel_cfg) |=>
         (prdata[cfg_ctl_pkg::TDO_USE_BIT] == $past(two_wire_output_pin_use));
   endproperty
   a_rd_tdo: assert property (p_rd_tdo) else $error("two-wire pin use read wrong");

   property p_rd_key;
      @(posedge clk) disable iff (!rst_n)
      (rd_setup && sel_key) |=> (prdata == {31'h0000_0000, $past(unlocked)});
   endproperty
   a_rd_key: assert property (p_rd_key) else $error("unlock state read wrong");

   property p_rd_unmapped;
      @(posedge clk) disable iff (!rst_n)
      (rd_setup && !mapped) |=> (prdata == 32'h0000_0000);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");

   // read data stands until the next read setup
   property p_rd_hold;
      @(posedge clk) disable iff (!rst_n)
      !rd_setup |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved between reads");
endmodule : config_control_lock_register

//--- test/config_control_lock_register_test.sv
// Purpose: self-checking bench for the configuration control register bank
// Assumes: apb slave as handed over, unlock keys from the package
// Notes:   reads are judged from a queue of expected words
// =============================================================
`timescale 1ns/1ps
module config_control_lock_register_test;
   localparam logic [11:0] NOWHERE = 12'h010;
   logic        clk     = 1'b0;
   logic        rstn    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, pin_sel, mod_dis, e_cfg, e_ps, e_md;
   logic        pready, pslverr, dbg_en, two_wire, pin_lock, mod_lock;
   logic [31:0] rnd = 32'h8688;
   logic [32:0] rq[$];
   int          miscompares = 0;
   int          check_count = 0;
   int          cyc = 0;
   // =============================================================
   // design and clock
   config_control_lock_register config_control_lock_register_i (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .debug_port_enable(dbg_en),
      .two_wire_output_pin_use(two_wire), .pin_select_lock(pin_lock),
      .module_disable_lock(mod_lock), .pin_select_registers(pin_sel),
      .module_disable_registers(mod_dis));
   always #2.5 clk = ~clk;
   // =============================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_bit(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   // one transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      rq.push_back(e);                   // every answer is judged, writes too
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // locks may only move after both keys; model mirrors that
   task automatic wcfg(input logic [31:0] d, input logic unl);
      if (unl) begin
         apb(1'b1, cfg_ctl_pkg::UNLOCK_KEY_OFS, cfg_ctl_pkg::UNLOCK_KEY1, 33'h0);
         apb(1'b1, cfg_ctl_pkg::UNLOCK_KEY_OFS, cfg_ctl_pkg::UNLOCK_KEY2, 33'h0);
      end
      apb(1'b1, cfg_ctl_pkg::CONFIG_CONTROL_OFS, d, 33'h0);
      e_cfg = {18'h0, unl ? d[13:12] : e_cfg[13:12], 8'h0, d[3], 2'b11, d[0]};
   endtask : wcfg
   task automatic wper(input logic [31:0] p, input logic [31:0] m);
      apb(1'b1, cfg_ctl_pkg::PIN_SELECT_OFS, p, 33'h0);
      apb(1'b1, cfg_ctl_pkg::MODULE_DISABLE_OFS, m, 33'h0);
      if (!e_cfg[13]) e_ps = p;
      if (!e_cfg[12]) e_md = m;
   endtask : wper
   task automatic verify(input string nm);
      apb(1'b0, cfg_ctl_pkg::CONFIG_CONTROL_OFS, 32'h0, {1'b0, e_cfg});
      @(negedge clk);
      chk_bit("pin lock", e_cfg[13], pin_lock);
      chk_bit("mod lock", e_cfg[12], mod_lock);
      chk_bit("debug en", e_cfg[3], dbg_en);
      chk_bit("two wire", e_cfg[0], two_wire);
      chk("pin sel", {1'b0, e_ps}, {1'b0, pin_sel});
      chk("mod dis", {1'b0, e_md}, {1'b0, mod_dis});
      $display("test %s done", nm);
   endtask : verify
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // =============================================================
   // answer watcher for reads and writes, and hang guard
   always @(posedge clk) begin
      if (psel && penable && pready)
         chk("answer", rq.pop_front(), {pslverr, pwrite ? 32'h0000_0000 : prdata});
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         complete_run();
      end
   end
   // =============================================================
   // main sequence
   initial begin
      e_cfg = 32'h0000_000F;
      e_ps  = 32'h0;
      e_md  = 32'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      verify("reset");
      // random words without keys: locks stay, data bits follow
      repeat (4) begin
         rnd = lfsr(rnd);
         wcfg(rnd, 1'b0);
         wper(rnd, ~rnd);
         verify("random");
      end
      wcfg(32'h0000_2009, 1'b1);
      wper(lfsr(rnd), rnd);
      verify("pin locked");
      wcfg(32'h0000_3000, 1'b0);
      verify("lock held");
      wcfg(32'h0000_3001, 1'b1);
      wper(~rnd, lfsr(~rnd));
      verify("both locked");
      wcfg(32'h0000_0008, 1'b1);
      wper(~rnd, lfsr(~rnd));
      verify("released");
      // key register shows the open state until a wrong key arrives
      apb(1'b1, cfg_ctl_pkg::UNLOCK_KEY_OFS, cfg_ctl_pkg::UNLOCK_KEY1, 33'h0);
      apb(1'b1, cfg_ctl_pkg::UNLOCK_KEY_OFS, cfg_ctl_pkg::UNLOCK_KEY2, 33'h0);
      apb(1'b0, cfg_ctl_pkg::UNLOCK_KEY_OFS, 32'h0, 33'h1);
      apb(1'b1, cfg_ctl_pkg::UNLOCK_KEY_OFS, 32'h0000_0000, 33'h0);
      apb(1'b0, cfg_ctl_pkg::UNLOCK_KEY_OFS, 32'h0, 33'h0);
      verify("key state");
      // unmapped place: error flag and zero data, write has no effect
      apb(1'b0, NOWHERE, 32'h0, 33'h1_0000_0000);
      apb(1'b1, NOWHERE, 32'hFFFF_FFFF, 33'h1_0000_0000);
      verify("unmapped");
      complete_run();
   end
endmodule : config_control_lock_register_test
